// ### src/lcd_cmd_decoder.sv
// lcd_cmd_decoder: command/data separation and control state of the display driver
// assumes a slave receiver delivering bytes with a one-cycle strobe after address match
// Summary of operation
// - bit 7 of each command byte is the continuation flag
// - flag one: next byte of the transfer is another command
// - flag zero: all later bytes until stop are display data
// - opcode 10 in bits 6:5 is mode set with power, enable, bias, mode
// - drive mode 01 static, 10 1:2, 11 1:3, 00 1:4
// - bias bit zero gives one-third, one gives one-half bias
// - enable bit zero blanks display, one enables it
// - low-power bit zero normal, one power saving
// - bit 6 zero loads six-bit data pointer, valid 0 to 39
// - bits 6:3 1100 loads three-bit subaddress counter
// - bits 6:2 11110 bank select; bit 1 input bank, bit 0 output
// - input bank picks RAM bit 0/0-1 or 2/2-3 for writes
// - output bank picks RAM bit 0/0-1 or 2/2-3 for display
// - bank select ignored in 1:3 and 1:4 drive modes
// - bits 6:3 1110 is blink; bit 2 mode, bits 1:0 rate
// - blink rate 00 off, 01 to 11 settings one to three
// - blink mode one swaps displayed and alternate banks in static and 1:2 drive modes
// - execute commands, hold status, fill RAM in drive mode order
// - blink dividers differ for normal and power saving mode
// - pointer advances after each data byte; subaddress advances only when pointer wraps past 39
// - data acknowledged only on subaddress match, commands by all
`timescale 1ns/10ps
`default_nettype none
module lcd_cmd_decoder #(
   parameter int RAM_DEPTH = lcd_pkg::RAM_DEPTH,
   parameter int BLINK_N1 = lcd_pkg::BLINK_DIV_N1,
   parameter int BLINK_N2 = lcd_pkg::BLINK_DIV_N2,
   parameter int BLINK_N3 = lcd_pkg::BLINK_DIV_N3,
   parameter int BLINK_P1 = lcd_pkg::BLINK_DIV_P1,
   parameter int BLINK_P2 = lcd_pkg::BLINK_DIV_P2,
   parameter int BLINK_P3 = lcd_pkg::BLINK_DIV_P3
) (
   input wire logic i_sys_clk, // display clock, 40 MHz
   input wire logic i_rst_n, // power-on reset, active low
   input wire logic i_xfer_start, // pulse: addressed transfer begins
   input wire logic i_byte_valid, // pulse: byte received
   input wire logic [7:0] i_byte, // received byte
   input wire logic [2:0] i_hw_subaddr, // subaddress pins, raw
   input wire logic [5:0] i_rd_addr, // display side RAM read address
   output logic o_ack, // pulse: byte to be acknowledged
   output logic o_low_power, // power saving mode
   output logic o_disp_en, // display enabled
   output logic o_bias_half, // one-half bias selected
   output logic [1:0] o_drive_mode, // multiplex mode field
   output logic [5:0] o_ram_ptr, // data pointer
   output logic [2:0] o_subaddr, // subaddress counter
   output logic o_in_bank, // input bank
   output logic o_out_bank, // effective output bank
   output logic o_blink_mode, // alternate bank blinking
   output logic [1:0] o_blink_rate, // blink rate
   output logic o_blink_phase, // blink phase
   output logic o_blank, // blanked by disable or blink
   output logic [3:0] o_rd_data // RAM word at read address
);
   logic [3:0] ram_ff [RAM_DEPTH];
   logic [2:0] sa_meta_ff, sa_sync_ff;
   lcd_pkg::lcd_rx_state_t st_ff, nxt_st;
   logic low_power_sel_ff, nxt_low_power_sel;
   logic disp_en_ff, nxt_disp_en;
   logic bias_ff, nxt_bias;
   logic [1:0] drive_mode_ff, nxt_drive_mode;
   logic [5:0] ptr_ff, nxt_ptr;
   logic [2:0] subaddr_ff, nxt_subaddr;
   logic in_bank_ff, nxt_in_bank;
   logic out_bank_ff, nxt_out_bank;
   logic blink_mode_ff, nxt_blink_mode;
   logic [1:0] blink_rate_ff, nxt_blink_rate;
   logic ack_ff, nxt_ack;
   logic wr_en;
   logic blink_phase;
   logic out_bank_eff;
   logic blank_ff, out_bank_o_ff;
   logic [3:0] rd_ff;

   function automatic logic is_mode_set(input logic [7:0] b);
      return b[6:5] == lcd_pkg::MODE_SET_CODE;
   endfunction : is_mode_set

   function automatic logic bank_allowed(input logic [1:0] m);
      return (m == lcd_pkg::DRV_STATIC) || (m == lcd_pkg::DRV_MUX2);
   endfunction : bank_allowed

   // subaddress pins come from outside: two-stage sync
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sa_meta_ff <= 3'h0;
         sa_sync_ff <= 3'h0;
      end else begin
         sa_meta_ff <= i_hw_subaddr;
         sa_sync_ff <= sa_meta_ff;
      end
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_low_power_sel = low_power_sel_ff;
      nxt_disp_en = disp_en_ff;
      nxt_bias = bias_ff;
      nxt_drive_mode = drive_mode_ff;
      nxt_ptr = ptr_ff;
      nxt_subaddr = subaddr_ff;
      nxt_in_bank = in_bank_ff;
      nxt_out_bank = out_bank_ff;
      nxt_blink_mode = blink_mode_ff;
      nxt_blink_rate = blink_rate_ff;
      nxt_ack = 1'b0;
      wr_en = 1'b0;
      if (i_xfer_start) begin
         nxt_st = lcd_pkg::ST_CMD;
      end else if (i_byte_valid) begin
         case (st_ff)
            lcd_pkg::ST_CMD: begin
               nxt_ack = 1'b1;
               nxt_st = i_byte[lcd_pkg::CMD_CONT_BIT] ? lcd_pkg::ST_CMD : lcd_pkg::ST_DATA;
               if (is_mode_set(i_byte)) begin
                  nxt_low_power_sel = i_byte[4];
                  nxt_disp_en = i_byte[3];
                  nxt_bias = i_byte[2];
                  nxt_drive_mode = i_byte[1:0];
               end else if (!i_byte[6]) begin
                  nxt_ptr = i_byte[5:0];
               end else if (i_byte[6:3] == lcd_pkg::DEV_SEL_CODE) begin
                  nxt_subaddr = i_byte[2:0];
               end else if (i_byte[6:2] == lcd_pkg::BANK_SEL_CODE) begin
                  // bank select gated by drive mode
                  if (bank_allowed(drive_mode_ff)) begin
                     nxt_in_bank = i_byte[1];
                     nxt_out_bank = i_byte[0];
                  end
               end else if (i_byte[6:3] == lcd_pkg::BLINK_CODE) begin
                  nxt_blink_mode = i_byte[2];
                  nxt_blink_rate = i_byte[1:0];
               end
            end
            lcd_pkg::ST_DATA: begin
               wr_en = (subaddr_ff == sa_sync_ff) && (ptr_ff <= lcd_pkg::RAM_LAST);
               nxt_ack = (subaddr_ff == sa_sync_ff);
               if (ptr_ff >= lcd_pkg::RAM_LAST) begin
                  nxt_ptr = 6'h0;
                  nxt_subaddr = subaddr_ff + 3'h1;
               end else begin
                  nxt_ptr = ptr_ff + 6'h1;
               end
            end
            default: nxt_st = lcd_pkg::ST_CMD;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_ff <= lcd_pkg::ST_CMD;
         low_power_sel_ff <= lcd_pkg::RST_LOW_POWER;
         disp_en_ff <= lcd_pkg::RST_DISP_EN;
         bias_ff <= lcd_pkg::RST_BIAS;
         drive_mode_ff <= lcd_pkg::RST_DRIVE_MODE;
         ptr_ff <= 6'h0;
         subaddr_ff <= 3'h0;
         in_bank_ff <= 1'b0;
         out_bank_ff <= 1'b0;
         blink_mode_ff <= 1'b0;
         blink_rate_ff <= lcd_pkg::RST_BLINK_RATE;
         ack_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         low_power_sel_ff <= nxt_low_power_sel;
         disp_en_ff <= nxt_disp_en;
         bias_ff <= nxt_bias;
         drive_mode_ff <= nxt_drive_mode;
         ptr_ff <= nxt_ptr;
         subaddr_ff <= nxt_subaddr;
         in_bank_ff <= nxt_in_bank;
         out_bank_ff <= nxt_out_bank;
         blink_mode_ff <= nxt_blink_mode;
         blink_rate_ff <= nxt_blink_rate;
         ack_ff <= nxt_ack;
      end
   end

   // RAM fill in drive mode order; input bank lanes
   always_ff @(posedge i_sys_clk) begin
      if (wr_en) begin
         case (drive_mode_ff)
            lcd_pkg::DRV_STATIC: ram_ff[ptr_ff][{in_bank_ff, 1'b0}] <= i_byte[7];
            lcd_pkg::DRV_MUX2: begin
               ram_ff[ptr_ff][{in_bank_ff, 1'b0}] <= i_byte[7];
               ram_ff[ptr_ff][{in_bank_ff, 1'b1}] <= i_byte[6];
            end
            default: ram_ff[ptr_ff] <= i_byte[7:4];
         endcase
      end
   end

   lcd_blink_gen #(
      .DIV_N1(BLINK_N1),
      .DIV_N2(BLINK_N2),
      .DIV_N3(BLINK_N3),
      .DIV_P1(BLINK_P1),
      .DIV_P2(BLINK_P2),
      .DIV_P3(BLINK_P3)
   ) u_blink (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_rate(blink_rate_ff),
      .i_low_power(low_power_sel_ff),
      .o_phase(blink_phase)
   );

   // output bank; alternate bank blinking swaps banks in static and 1:2 modes
   assign out_bank_eff = out_bank_ff ^ (blink_mode_ff && blink_phase && bank_allowed(drive_mode_ff));

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         blank_ff <= 1'b1;
         out_bank_o_ff <= 1'b0;
         rd_ff <= 4'h0;
      end else begin
         // blank when disabled or in normal blink off-phase
         blank_ff <= !disp_en_ff || (!blink_mode_ff && blink_phase);
         out_bank_o_ff <= out_bank_eff;
         rd_ff <= (i_rd_addr <= lcd_pkg::RAM_LAST) ? ram_ff[i_rd_addr] : 4'h0;
      end
   end

   assign o_ack = ack_ff;
   assign o_low_power = low_power_sel_ff;
   assign o_disp_en = disp_en_ff;
   assign o_bias_half = bias_ff;
   assign o_drive_mode = drive_mode_ff;
   assign o_ram_ptr = ptr_ff;
   assign o_subaddr = subaddr_ff;
   assign o_in_bank = in_bank_ff;
   assign o_out_bank = out_bank_o_ff;
   assign o_blink_mode = blink_mode_ff;
   assign o_blink_rate = blink_rate_ff;
   assign o_blink_phase = blink_phase;
   assign o_blank = blank_ff;
   assign o_rd_data = rd_ff;

   a_cont_to_data: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && !i_xfer_start && st_ff == lcd_pkg::ST_CMD && !i_byte[7]) |=> st_ff == lcd_pkg::ST_DATA)
      else $error("cleared flag did not end commands");
   a_cont_stays_cmd: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && !i_xfer_start && st_ff == lcd_pkg::ST_CMD && i_byte[7]) |=> st_ff == lcd_pkg::ST_CMD)
      else $error("set flag left command phase");
   a_mode_set_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && !i_xfer_start && st_ff == lcd_pkg::ST_CMD && i_byte[6:5] == 2'h2)
      |=> (drive_mode_ff == $past(i_byte[1:0]) && low_power_sel_ff == $past(i_byte[4])
           && disp_en_ff == $past(i_byte[3]) && bias_ff == $past(i_byte[2])))
      else $error("mode set fields not loaded");
   a_ptr_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && !i_xfer_start && st_ff == lcd_pkg::ST_CMD && !i_byte[6]) |=> ptr_ff == $past(i_byte[5:0]))
      else $error("data pointer not loaded");
   a_subaddr_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && !i_xfer_start && st_ff == lcd_pkg::ST_CMD && i_byte[6:3] == 4'hc)
      |=> subaddr_ff == $past(i_byte[2:0])) else $error("subaddress not loaded");
   a_bank_blocked: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && st_ff == lcd_pkg::ST_CMD && !bank_allowed(drive_mode_ff))
      |=> $stable(in_bank_ff) && $stable(out_bank_ff)) else $error("bank changed in 1:3 or 1:4");
   a_blink_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && !i_xfer_start && st_ff == lcd_pkg::ST_CMD && i_byte[6:3] == 4'he)
      |=> blink_rate_ff == $past(i_byte[1:0]) && blink_mode_ff == $past(i_byte[2]))
      else $error("blink fields not loaded");
   a_data_advance: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && !i_xfer_start && st_ff == lcd_pkg::ST_DATA && ptr_ff < lcd_pkg::RAM_LAST)
      |=> ptr_ff == $past(ptr_ff) + 6'h1 && $stable(subaddr_ff)) else $error("pointer did not advance");
   a_data_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && !i_xfer_start && st_ff == lcd_pkg::ST_DATA && ptr_ff >= lcd_pkg::RAM_LAST)
      |=> ptr_ff == 6'h0 && subaddr_ff == $past(subaddr_ff) + 3'h1) else $error("pointer did not wrap");
   a_data_ack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && !i_xfer_start && st_ff == lcd_pkg::ST_DATA && subaddr_ff != sa_sync_ff) |=> !ack_ff)
      else $error("data acknowledged by wrong subaddress");
   a_cmd_ack_all: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_byte_valid && !i_xfer_start && st_ff == lcd_pkg::ST_CMD) |=> ack_ff)
      else $error("command byte not acknowledged");
   a_data_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_en |-> (subaddr_ff == sa_sync_ff)) else $error("write to foreign subaddress");
   a_blank_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !disp_en_ff |=> blank_ff) else $error("disabled display not blanked");
   a_out_bank_fix: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !blink_mode_ff |=> out_bank_o_ff == $past(out_bank_ff)) else $error("output bank not followed");
endmodule : lcd_cmd_decoder
`default_nettype wire

// ### src/lcd_pkg.sv
// lcd_pkg: constants for the display driver command decoder
// assumes a byte receiver upstream that marks transfer start and each received byte
package lcd_pkg;
   localparam int CMD_CONT_BIT = 7;
   localparam logic [1:0] MODE_SET_CODE = 2'h2;
   localparam logic [3:0] DEV_SEL_CODE = 4'hc;
   localparam logic [4:0] BANK_SEL_CODE = 5'h1e;
   localparam logic [3:0] BLINK_CODE = 4'he;
   localparam logic [1:0] DRV_STATIC = 2'h1;
   localparam logic [1:0] DRV_MUX2 = 2'h2;
   localparam logic [1:0] DRV_MUX3 = 2'h3;
   localparam logic [1:0] DRV_MUX4 = 2'h0;
   localparam int RAM_DEPTH = 40;
   localparam logic [5:0] RAM_LAST = 6'h27;
   // reset state of control fields
   localparam logic [1:0] RST_DRIVE_MODE = 2'h0;
   localparam logic RST_BIAS = 1'b0;
   localparam logic RST_DISP_EN = 1'b0;
   localparam logic RST_LOW_POWER = 1'b0;
   localparam logic [1:0] RST_BLINK_RATE = 2'h0;
   // blink dividers: display clock cycles per blink period
   localparam int BLINK_DIV_N1 = 92160;
   localparam int BLINK_DIV_N2 = 184320;
   localparam int BLINK_DIV_N3 = 368640;
   localparam int BLINK_DIV_P1 = 15360;
   localparam int BLINK_DIV_P2 = 30720;
   localparam int BLINK_DIV_P3 = 61440;
   typedef enum logic [1:0] {
      ST_CMD = 2'b01,
      ST_DATA = 2'b10
   } lcd_rx_state_t;
endpackage : lcd_pkg

// ### src/lcd_blink_gen.sv
// lcd_blink_gen: blink phase generator dividing the display clock
// assumes rate and power-saving selection come from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module lcd_blink_gen #(
   parameter int DIV_N1 = lcd_pkg::BLINK_DIV_N1,
   parameter int DIV_N2 = lcd_pkg::BLINK_DIV_N2,
   parameter int DIV_N3 = lcd_pkg::BLINK_DIV_N3,
   parameter int DIV_P1 = lcd_pkg::BLINK_DIV_P1,
   parameter int DIV_P2 = lcd_pkg::BLINK_DIV_P2,
   parameter int DIV_P3 = lcd_pkg::BLINK_DIV_P3
) (
   input wire logic i_sys_clk, // display clock
   input wire logic i_rst_n, // async reset
   input wire logic [1:0] i_rate, // blink rate, 0 = off
   input wire logic i_low_power, // power saving divider set
   output logic o_phase // toggles every half period
);
   logic [18:0] cnt_ff, nxt_cnt;
   logic phase_ff, nxt_phase;
   logic [18:0] half;

   always_comb begin
      case ({i_low_power, i_rate})
         3'h1: half = 19'(DIV_N1 / 2);
         3'h2: half = 19'(DIV_N2 / 2);
         3'h3: half = 19'(DIV_N3 / 2);
         3'h5: half = 19'(DIV_P1 / 2);
         3'h6: half = 19'(DIV_P2 / 2);
         3'h7: half = 19'(DIV_P3 / 2);
         default: half = 19'h1;
      endcase
   end

   always_comb begin
      nxt_cnt = cnt_ff + 19'h1;
      nxt_phase = phase_ff;
      if (i_rate == 2'h0) begin
         nxt_cnt = 19'h0;
         nxt_phase = 1'b0;
      end else if (nxt_cnt >= half) begin
         nxt_cnt = 19'h0;
         nxt_phase = ~phase_ff;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= 19'h0;
         phase_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         phase_ff <= nxt_phase;
      end
   end

   assign o_phase = phase_ff;

   a_blink_off_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rate == 2'h0) |=> !phase_ff) else $error("blink phase active while off");
endmodule : lcd_blink_gen
`default_nettype wire

// ### verification/lcd_host_model.sv
// lcd_host_model: upstream byte source standing in for the serial bus master
// assumes the decoder samples on the rising edge, so requests move on the falling edge
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
   input wire logic i_sys_clk, // display clock
   input wire logic i_ack, // acknowledge pulse from decoder
   output logic o_xfer_start, // transfer start pulse
   output logic o_byte_valid, // byte strobe
   output logic [7:0] o_byte // byte lines
);
   initial begin
      o_xfer_start = 1'b0;
      o_byte_valid = 1'b0;
      o_byte = 8'h00;
   end

   task automatic start_xfer();
      @(negedge i_sys_clk);
      o_xfer_start = 1'b1;
      @(negedge i_sys_clk);
      o_xfer_start = 1'b0;
   endtask : start_xfer

   // enable toggling is just more mode-set bytes
   task automatic put_byte(input logic [7:0] b, output logic ack);
      @(negedge i_sys_clk);
      o_byte_valid = 1'b1;
      o_byte = b;
      @(negedge i_sys_clk);
      // the acknowledge pulse stands only in the cycle after the byte is taken
      ack = i_ack;
      o_byte_valid = 1'b0;
      // released lines do not keep the last byte
      o_byte = ~b;
      // one more edge so registered status outputs have settled on return
      @(negedge i_sys_clk);
   endtask : put_byte
endmodule : lcd_host_model
`default_nettype wire

// ### verification/lcd_cmd_decoder_tb_top.sv
// lcd_cmd_decoder_tb_top: self-checking bench for the command decoder
// assumes short blink dividers 8,16,32,4,8 (last low-power one at default) and own subaddress 2
`timescale 1ns/10ps
`default_nettype none
module lcd_cmd_decoder_tb_top;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic xfer_start, byte_valid, ack, low_power, disp_en, bias_half;
   logic out_bank, in_bank, blink_mode, blink_phase, blank;
   logic [7:0] rx_byte;
   logic [2:0] hw_subaddr = 3'h2;
   logic [5:0] rd_addr = 6'h00;
   logic [1:0] drive_mode, blink_rate;
   logic [5:0] ram_ptr;
   logic [2:0] subaddr;
   logic [3:0] rd_data;
   int err_total = 0;
   int checks = 0;

   always #12.5 sys_clk = ~sys_clk;

   lcd_host_model host_u (.i_sys_clk(sys_clk), .i_ack(ack), .o_xfer_start(xfer_start),
      .o_byte_valid(byte_valid), .o_byte(rx_byte));

   lcd_cmd_decoder #(.BLINK_N1(8), .BLINK_N2(16), .BLINK_N3(32), .BLINK_P1(4), .BLINK_P2(8))
      dut_u (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_xfer_start(xfer_start),
      .i_byte_valid(byte_valid), .i_byte(rx_byte), .i_hw_subaddr(hw_subaddr), .i_rd_addr(rd_addr),
      .o_ack(ack), .o_low_power(low_power), .o_disp_en(disp_en), .o_bias_half(bias_half),
      .o_drive_mode(drive_mode), .o_ram_ptr(ram_ptr), .o_subaddr(subaddr), .o_in_bank(in_bank),
      .o_out_bank(out_bank), .o_blink_mode(blink_mode), .o_blink_rate(blink_rate),
      .o_blink_phase(blink_phase), .o_blank(blank), .o_rd_data(rd_data));

   task automatic end_sim();
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // sends one byte and compares the acknowledge
   task automatic tx(input logic [7:0] b, input logic exp_ack);
      logic a;
      host_u.put_byte(b, a);
      chk({7'h00, a}, {7'h00, exp_ack});
   endtask : tx

   task automatic rd(input logic [5:0] a, input logic [3:0] exp);
      @(negedge sys_clk);
      rd_addr = a;
      @(negedge sys_clk);
      chk({4'h0, rd_data}, {4'h0, exp});
   endtask : rd

   task automatic reset_check();
      chk({6'h00, drive_mode}, 8'h00);
      chk({disp_en, low_power, bias_half, in_bank, blink_mode, blank, blink_rate}, 8'h04);
      chk({2'h0, ram_ptr}, 8'h00);
      chk({5'h00, subaddr}, 8'h00);
   endtask : reset_check

   // counts blank transitions over a window of cycles
   task automatic count_toggles(input int n, output int cnt);
      logic last;
      cnt = 0;
      last = blank;
      repeat (n) begin
         @(negedge sys_clk);
         if (blank !== last)
            cnt++;
         last = blank;
      end
   endtask : count_toggles

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      end_sim();
   end

   initial begin
      logic [1:0] m;
      int cnt;
      int exp_cnt;
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      reset_check();
      repeat (2) @(negedge sys_clk);
      // every drive mode with varied power, enable and bias bits
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         host_u.start_xfer();
         tx({3'b010, m[0], ~m[0], m[1], m}, 1'b1);
         chk({6'h00, drive_mode}, {6'h00, m});
         chk({5'h00, low_power, disp_en, bias_half}, {5'h00, m[0], ~m[0], m[1]});
         chk({7'h00, blank}, {7'h00, m[0]});
      end
      // chained commands with an unknown opcode in the middle
      host_u.start_xfer();
      tx(8'hc9, 1'b1);
      tx(8'hfc, 1'b1);
      chk({drive_mode, disp_en, low_power}, 8'h06);
      tx(8'h7b, 1'b1);
      chk({6'h00, in_bank, out_bank}, 8'h03);
      // data for subaddress 2 while counter is 0: no ack, pointer still moves
      chk({2'h0, ram_ptr}, 8'h00);
      tx(8'h80, 1'b0);
      chk({2'h0, ram_ptr}, 8'h01);
      // 1:4 mode, pointer at end of range, wrap into next subaddress
      host_u.start_xfer();
      tx(8'he2, 1'b1);
      tx(8'hc8, 1'b1);
      tx(8'h26, 1'b1);
      chk({ram_ptr, 2'h0}, {6'h26, 2'h0});
      tx(8'ha5, 1'b1);
      tx(8'h3c, 1'b1);
      chk({ram_ptr, subaddr[1:0]}, 8'h03);
      tx(8'hff, 1'b0);
      rd(6'h26, 4'ha);
      rd(6'h27, 4'h3);
      // bank select refused in 1:4 mode
      host_u.start_xfer();
      tx(8'h78, 1'b1);
      chk({7'h00, in_bank}, 8'h01);
      // clear words 5 and 6 in 1:4 mode, so that every lane is known
      host_u.start_xfer();
      tx(8'he2, 1'b1);
      tx(8'h05, 1'b1);
      tx(8'h00, 1'b1);
      tx(8'h00, 1'b1);
      // static mode writes only RAM bit 2 of the input bank
      host_u.start_xfer();
      tx(8'hc9, 1'b1);
      tx(8'h85, 1'b1);
      tx(8'h62, 1'b1);
      tx(8'h80, 1'b1);
      tx(8'h00, 1'b1);
      chk({2'h0, ram_ptr}, 8'h07);
      rd(6'h05, 4'h4);
      chk({7'h00, rd_data[2]}, 8'h01);
      rd(6'h06, 4'h0);
      // normal blink at each rate, toggle count against the divider
      for (int r = 0; r < 4; r++) begin
         m = r[1:0];
         host_u.start_xfer();
         tx({5'b01110, 1'b0, m}, 1'b1);
         chk({5'h00, blink_mode, blink_rate}, {6'h00, m});
         count_toggles(64, cnt);
         exp_cnt = (r == 0) ? 0 : 64 / (4 << (r - 1));
         chk({7'h00, (cnt >= exp_cnt - 1 && cnt <= exp_cnt + 1)}, 8'h01);
      end
      // power saving mode uses the shorter divider for setting one
      host_u.start_xfer();
      tx(8'hd9, 1'b1);
      tx(8'h71, 1'b1);
      count_toggles(64, cnt);
      chk({7'h00, (cnt >= 31 && cnt <= 33)}, 8'h01);
      // alternate bank blink swaps the displayed bank
      host_u.start_xfer();
      tx(8'h75, 1'b1);
      chk({6'h00, blink_mode, blink_rate[0]}, 8'h03);
      cnt = 0;
      repeat (16) begin
         @(negedge sys_clk);
         if (out_bank === 1'b0)
            cnt++;
      end
      chk({7'h00, (cnt > 0 && cnt < 16)}, 8'h01);
      // a second reset in mid-run clears the control state
      @(negedge sys_clk);
      rst_n = 1'b0;
      @(negedge sys_clk);
      reset_check();
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      // commands are taken again after the second release
      host_u.start_xfer();
      tx(8'h4c, 1'b1);
      chk({6'h00, disp_en, bias_half}, 8'h03);
      end_sim();
   end
endmodule : lcd_cmd_decoder_tb_top
`default_nettype wire
